// ==== exec_unit.sv ====
// Execution unit for subtract, XOR, swap, direction load and sleep entry
//
// Overview of operation
// - Literal minus accumulator goes to accumulator, updating carry, nibble and zero.
// - Carry set when subtrahend <= minuend; nibble bit same on low nibbles.
// - Register minus accumulator goes to selected destination, address 0 to 127.
// - Destination bit 0 writes accumulator, 1 writes the addressed register.
// - Borrow form also subtracts inverted carry; updates carry, nibble and zero.
// - Swap exchanges register nibbles to destination, flags untouched.
// - Literal XOR accumulator goes to accumulator; only zero flag changes.
// - Register XOR accumulator goes to destination; only zero flag changes.
// - Direction load copies accumulator to port A, B, C for 5, 6, 7.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears sleep entry bit and sets watchdog expiry bit.
// - After sleep, execution halts and the main oscillator stops.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module exec_unit #(
  parameter logic [7:0] PRESCALE = exec_pkg::WDOG_PRESCALE
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [exec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [exec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic sleeping,
  output logic osc_enable
);
  import exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the unit except the register file memory
  typedef struct packed {
    logic aw_v;
    logic [ADDR_W-1:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] acc;
    logic carry;
    logic nibble_borrow_bit;
    logic zero;
    logic sleep_entry_bit;
    logic watchdog_expiry_bit;
    logic sleep;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] watchdog_counter;
    logic [7:0] prescale_cnt;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Register file: too many words for the state struct
  logic [7:0] file_mem [FILE_DEPTH];
  logic file_we;
  logic [FILE_AW-1:0] file_waddr;
  logic [7:0] file_wdata;

  alu_in_t alu_in;
  alu_out_t alu_out;

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers, used by both the read and the write paths
  function automatic logic is_file(input logic [ADDR_W-1:0] a);
    is_file = (a[ADDR_W-1:9] == FILE_PAGE) && (a[1:0] == 2'b00);
  endfunction : is_file

  function automatic logic [FILE_AW-1:0] file_idx(
      input logic [ADDR_W-1:0] a);
    file_idx = a[FILE_AW+1:2];
  endfunction : file_idx

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields of the held write word
  logic [3:0] op;
  logic [7:0] lit;
  logic dest_file;
  logic [FILE_AW-1:0] faddr;
  logic do_write;

  assign op = s_q.w_data[OP_LSB +: 4];
  assign lit = s_q.w_data[LIT_LSB +: 8];
  assign dest_file = s_q.w_data[DEST_BIT];
  assign faddr = lit[FILE_AW-1:0];
  // A write is carried out once address and data are both held
  assign do_write = s_q.aw_v && s_q.w_v && !s_q.bvalid;

  // Operands for the datapath
  always_comb begin
    alu_in.op = op;
    alu_in.acc = s_q.acc;
    alu_in.fval = file_mem[faddr];
    alu_in.lit = lit;
    alu_in.carry = s_q.carry;
  end

  exec_alu u_alu (
    .a_i(alu_in),
    .r_o(alu_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs; one write and one read in flight at a time
  assign s_axi_awready = !s_q.aw_v;
  assign s_axi_wready = !s_q.w_v;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign port_a_direction = s_q.dir_a;
  assign port_b_direction = s_q.dir_b;
  assign port_c_direction = s_q.dir_c;
  assign sleeping = s_q.sleep;
  // Core clock gate request; the watchdog keeps its own source alive
  assign osc_enable = !s_q.sleep;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d = s_q;
    file_we = 1'b0;
    file_waddr = faddr;
    file_wdata = alu_out.res;

    // Watchdog prescaler and counter keep running; sleep entry below wins
    if (s_q.prescale_cnt == PRESCALE) begin
      s_d.prescale_cnt = 8'h00;
      s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
    end else begin
      s_d.prescale_cnt = s_q.prescale_cnt + 8'h01;
    end

    // Address and data channels are taken independently
    if (s_axi_awvalid && !s_q.aw_v) begin
      s_d.aw_v = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_v) begin
      s_d.w_v = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // Response leaves once the master takes it
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    if (do_write) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.aw_addr == REG_INSTR) begin
        // Halted core refuses instructions; partial words are malformed
        if (s_q.sleep || (s_q.w_strb[1:0] != 2'b11)) begin
          s_d.bresp = RESP_SLVERR;
        end else begin
          case (op)
            OP_LITERAL_MINUS_ACC, OP_LITERAL_XOR_ACC: begin
              s_d.acc = alu_out.res;
            end
            OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_BORROW,
            OP_NIBBLE_EXCHANGE, OP_FILE_XOR_ACC: begin
              if (dest_file) begin
                file_we = 1'b1;
              end else begin
                s_d.acc = alu_out.res;
              end
            end
            OP_DIRECTION_LOAD: begin
              // Only operands 5..7 name a direction register
              case (faddr)
                DIR_SEL_A: s_d.dir_a = s_q.acc;
                DIR_SEL_B: s_d.dir_b = s_q.acc;
                DIR_SEL_C: s_d.dir_c = s_q.acc;
                default: s_d.bresp = RESP_SLVERR;
              endcase
            end
            OP_SLEEP: begin
              s_d.watchdog_counter = 8'h00;
              s_d.prescale_cnt = 8'h00;
              s_d.sleep_entry_bit = 1'b0;
              s_d.watchdog_expiry_bit = 1'b1;
              s_d.sleep = 1'b1;
            end
            default: begin
              s_d.bresp = RESP_SLVERR;
            end
          endcase
          // Flags move only for the operations that own them
          if (alu_out.upd_cdc) begin
            s_d.carry = alu_out.carry;
            s_d.nibble_borrow_bit = alu_out.nibble;
          end
          if (alu_out.upd_z) begin
            s_d.zero = alu_out.zero;
          end
        end
      end else if (s_q.aw_addr == REG_ACC) begin
        if (s_q.w_strb[0]) begin
          s_d.acc = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == REG_STATUS) begin
        // Arithmetic flags are writable; power bits are read only
        if (s_q.w_strb[0]) begin
          s_d.carry = s_q.w_data[ST_CARRY];
          s_d.nibble_borrow_bit = s_q.w_data[ST_NIBBLE];
          s_d.zero = s_q.w_data[ST_ZERO];
        end
      end else if (s_q.aw_addr == REG_WAKE) begin
        // Software wake stands in for the wake sources outside this unit
        if (s_q.w_strb[0] && s_q.w_data[WAKE_BIT]) begin
          s_d.sleep = 1'b0;
        end
      end else if (is_file(s_q.aw_addr)) begin
        if (s_q.w_strb[0]) begin
          file_we = 1'b1;
          file_waddr = file_idx(s_q.aw_addr);
          file_wdata = s_q.w_data[7:0];
        end
      end else begin
        // Read-only and unmapped addresses
        s_d.bresp = RESP_SLVERR;
      end
    end

    // Read channel: data is formed when the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (s_axi_araddr == REG_INSTR) begin
        s_d.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == REG_ACC) begin
        s_d.rdata[7:0] = s_q.acc;
      end else if (s_axi_araddr == REG_STATUS) begin
        s_d.rdata[ST_CARRY] = s_q.carry;
        s_d.rdata[ST_NIBBLE] = s_q.nibble_borrow_bit;
        s_d.rdata[ST_ZERO] = s_q.zero;
        s_d.rdata[ST_SLEEP_ENTRY] = s_q.sleep_entry_bit;
        s_d.rdata[ST_WD_EXPIRY] = s_q.watchdog_expiry_bit;
        s_d.rdata[ST_SLEEPING] = s_q.sleep;
      end else if (s_axi_araddr == REG_DIR) begin
        s_d.rdata[23:0] = {s_q.dir_c, s_q.dir_b, s_q.dir_a};
      end else if (s_axi_araddr == REG_WAKE) begin
        s_d.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == REG_WDOG) begin
        s_d.rdata[15:0] = {s_q.prescale_cnt, s_q.watchdog_counter};
      end else if (is_file(s_axi_araddr)) begin
        s_d.rdata[7:0] = file_mem[file_idx(s_axi_araddr)];
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.acc <= ACC_RST;
      s_q.dir_a <= DIR_RST;
      s_q.dir_b <= DIR_RST;
      s_q.dir_c <= DIR_RST;
      s_q.sleep_entry_bit <= SLEEP_ENTRY_RST;
      s_q.watchdog_expiry_bit <= WD_EXPIRY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Register file; contents are not reset, like ordinary data memory
  always_ff @(posedge ref_clk) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

endmodule : exec_unit

// ==== exec_pkg.sv ====
// Shared constants, encodings and carrier types of the execution unit
package exec_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_INSTR = 12'h000;
  localparam logic [ADDR_W-1:0] REG_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] REG_DIR = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_WAKE = 12'h010;
  localparam logic [ADDR_W-1:0] REG_WDOG = 12'h014;
  // Register file words sit at 0x200 + 4*f, f = 0..127
  localparam logic [2:0] FILE_PAGE = 3'h1;

  // Instruction word fields
  localparam int LIT_LSB = 0;
  localparam int DEST_BIT = 8;
  localparam int OP_LSB = 12;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;

  // Status word bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP_ENTRY = 3;
  localparam int ST_WD_EXPIRY = 4;
  localparam int ST_SLEEPING = 5;
  localparam int WAKE_BIT = 0;

  // Operation codes
  localparam logic [3:0] OP_LITERAL_MINUS_ACC = 4'h1;
  localparam logic [3:0] OP_FILE_MINUS_ACC = 4'h2;
  localparam logic [3:0] OP_FILE_MINUS_ACC_BORROW = 4'h3;
  localparam logic [3:0] OP_NIBBLE_EXCHANGE = 4'h4;
  localparam logic [3:0] OP_LITERAL_XOR_ACC = 4'h5;
  localparam logic [3:0] OP_FILE_XOR_ACC = 4'h6;
  localparam logic [3:0] OP_DIRECTION_LOAD = 4'h7;
  localparam logic [3:0] OP_SLEEP = 4'h8;

  // Direction load operands
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic SLEEP_ENTRY_RST = 1'b1;
  localparam logic WD_EXPIRY_RST = 1'b1;
  localparam logic [7:0] WDOG_PRESCALE = 8'hff;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Operands handed to the arithmetic unit
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] acc;
    logic [7:0] fval;
    logic [7:0] lit;
    logic carry;
  } alu_in_t;

  // Result and flag updates from the arithmetic unit
  typedef struct packed {
    logic [7:0] res;
    logic carry;
    logic nibble;
    logic zero;
    logic upd_cdc;
    logic upd_z;
  } alu_out_t;

endpackage : exec_pkg

// ==== exec_alu.sv ====
// Combinational subtract, exclusive OR and nibble exchange datapath
`timescale 1ns/10ps
module exec_alu (
  input exec_pkg::alu_in_t a_i,
  output exec_pkg::alu_out_t r_o
);
  import exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Minuend minus subtrahend as minuend + ~subtrahend + carry-in; the carry
  // out is the "no borrow" flag, so carry = 1 when subtrahend <= minuend
  function automatic logic [8:0] sub9(input logic [7:0] m,
                                      input logic [7:0] s,
                                      input logic cin);
    sub9 = {1'b0, m} + {1'b0, ~s} + {8'h00, cin};
  endfunction : sub9

  function automatic logic [4:0] sub5(input logic [3:0] m,
                                      input logic [3:0] s,
                                      input logic cin);
    sub5 = {1'b0, m} + {1'b0, ~s} + {4'h0, cin};
  endfunction : sub5

  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] mnd;
  logic cin;

  // Operand selection and result forming
  always_comb begin
    mnd = (a_i.op == OP_LITERAL_MINUS_ACC) ? a_i.lit : a_i.fval;
    // Borrow variant subtracts the inverted carry as well
    cin = (a_i.op == OP_FILE_MINUS_ACC_BORROW) ? a_i.carry : 1'b1;
    diff = sub9(mnd, a_i.acc, cin);
    ndiff = sub5(mnd[3:0], a_i.acc[3:0], cin);
    r_o = '0;
    case (a_i.op)
      OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC,
      OP_FILE_MINUS_ACC_BORROW: begin
        r_o.res = diff[7:0];
        r_o.carry = diff[8];
        r_o.nibble = ndiff[4];
        r_o.upd_cdc = 1'b1;
        r_o.upd_z = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        r_o.res = {a_i.fval[3:0], a_i.fval[7:4]};
      end
      OP_LITERAL_XOR_ACC: begin
        r_o.res = a_i.acc ^ a_i.lit;
        r_o.upd_z = 1'b1;
      end
      OP_FILE_XOR_ACC: begin
        r_o.res = a_i.acc ^ a_i.fval;
        r_o.upd_z = 1'b1;
      end
      default: begin
        r_o.res = a_i.acc;
      end
    endcase
    r_o.zero = (r_o.res == 8'h00);
  end

endmodule : exec_alu

// ==== exec_unit_checker.sv ====
// Port-level assertions for the execution unit
`timescale 1ns/10ps
module exec_unit_checker
  import exec_pkg::*;
#(
  parameter logic [7:0] PRESCALE = exec_pkg::WDOG_PRESCALE
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [exec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [exec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_c_direction,
  input wire logic sleeping,
  input wire logic osc_enable
);
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] rd_addr_d;
  logic wr_w, instr_w, sleep_w, dir_a_w, dir_b_w, dir_c_w;
  logic [3:0] op;

  ////////////////////////////////////////////////////////////
  // Remember which register a read answer belongs to
  always_comb rd_addr_d = (s_axi_arvalid && s_axi_arready) ?
    s_axi_araddr : rd_addr_q;
  always_ff @(posedge ref_clk) rd_addr_q <= rd_addr_d;

  // Instruction writes taken with address and data on the same edge
  assign op = s_axi_wdata[15:12];
  assign wr_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == REG_INSTR && s_axi_wstrb[1:0] == 2'b11;
  assign instr_w = wr_w && !sleeping;
  assign sleep_w = instr_w && op == OP_SLEEP;
  assign dir_a_w = instr_w && op == OP_DIRECTION_LOAD &&
    s_axi_wdata[6:0] == DIR_SEL_A;
  assign dir_b_w = instr_w && op == OP_DIRECTION_LOAD &&
    s_axi_wdata[6:0] == DIR_SEL_B;
  assign dir_c_w = instr_w && op == OP_DIRECTION_LOAD &&
    s_axi_wdata[6:0] == DIR_SEL_C;

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence sleep_req_s;
    sleep_w;
  endsequence
  sequence halted_s;
    sleeping && !osc_enable;
  endsequence

  // Halt comes only from an accepted sleep, and within two edges of it
  AST_SLEEP_HALT: assert property (sleep_req_s |-> ##[1:2] halted_s)
    else $error("sleep did not halt");
  AST_SLEEP_CAUSE: assert property ($rose(sleeping) |->
    $past(sleep_w, 1) || $past(sleep_w, 2))
    else $error("halt without sleep");
  AST_OSC_STOP: assert property (osc_enable == !sleeping)
    else $error("oscillator enable wrong");
  AST_SLEEP_REFUSE: assert property (wr_w && sleeping |->
    ##[1:3] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("instruction accepted while halted");
  AST_SLEEP_BITS: assert property (s_axi_rvalid &&
    rd_addr_q == REG_STATUS && s_axi_rdata[ST_SLEEPING] |->
    !s_axi_rdata[ST_SLEEP_ENTRY] && s_axi_rdata[ST_WD_EXPIRY])
    else $error("status bits wrong while halted");
  // Direction registers move only after a matching direction load
  AST_DIR_A: assert property ($changed(port_a_direction) |->
    $past(dir_a_w, 1) || $past(dir_a_w, 2))
    else $error("port a direction changed");
  AST_DIR_B: assert property ($changed(port_b_direction) |->
    $past(dir_b_w, 1) || $past(dir_b_w, 2))
    else $error("port b direction changed");
  AST_DIR_C: assert property ($changed(port_c_direction) |->
    $past(dir_c_w, 1) || $past(dir_c_w, 2))
    else $error("port c direction changed");
endmodule : exec_unit_checker

// ==== subtract_xor_swap_sleep_ops_tb.sv ====
// Self-checking bench for the execution unit
`timescale 1ns/10ps
module subtract_xor_swap_sleep_ops_tb;
  import exec_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sleeping, osc_enable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] dir_a, dir_b, dir_c;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  // Fast watchdog prescale keeps the counter visible in a short run
  exec_unit #(.PRESCALE(8'h03)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .sleeping(sleeping), .osc_enable(osc_enable)
  );

  initial forever #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write: address and data offered together, bready always high
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
    chk("rresp", 32'(RESP_OKAY), 32'(r));
  endtask : rchk

  task automatic ins(input logic [3:0] op, input logic [8:0] x,
                     input logic [1:0] er);
    wr(REG_INSTR, {16'h0, op, 3'h0, x}, er);
  endtask : ins

  function automatic logic [11:0] fa(input logic [6:0] f);
    return {FILE_PAGE, f, 2'b00};
  endfunction : fa

  // One instruction with flags preset to DC=1, Z=1, C=cin
  task automatic run(input logic [3:0] op, input logic [6:0] f,
                     input logic d, input logic [7:0] m,
                     input logic [7:0] a, input logic cin);
    logic lit, sub, bw;
    logic [8:0] full;
    logic [4:0] nib;
    logic [7:0] res;
    logic [2:0] st;
    lit = op == OP_LITERAL_MINUS_ACC || op == OP_LITERAL_XOR_ACC;
    sub = op inside {OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC,
                     OP_FILE_MINUS_ACC_BORROW};
    bw = op == OP_FILE_MINUS_ACC_BORROW && !cin;
    full = {1'b0, m} - {1'b0, a} - 9'(bw);
    nib = {1'b0, m[3:0]} - {1'b0, a[3:0]} - 5'(bw);
    res = (op == OP_NIBBLE_EXCHANGE) ? {m[3:0], m[7:4]} :
          sub ? full[7:0] : m ^ a;
    st = {2'b11, cin};
    if (sub) st = {res == 8'h00, !nib[4], !full[8]};
    else if (op != OP_NIBBLE_EXCHANGE) st[2] = res == 8'h00;
    wr(REG_ACC, 32'(a), RESP_OKAY);
    wr(REG_STATUS, 32'({2'b11, cin}), RESP_OKAY);
    if (!lit) wr(fa(f), 32'(m), RESP_OKAY);
    ins(op, lit ? {1'b0, m} : {d, 1'b0, f}, RESP_OKAY);
    rchk("acc", REG_ACC, 32'((d && !lit) ? a : res));
    if (!lit) rchk("file", fa(f), 32'(d ? res : m));
    rchk("status", REG_STATUS, 32'({3'b011, st}));
  endtask : run

  ////////////////////////////////////////////////////////////
  // Hang guard: the whole sequence needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rchk("status", REG_STATUS, 32'h18);
    rchk("dir", REG_DIR, 32'h00ffffff);
    run(OP_LITERAL_MINUS_ACC, 0, 0, 8'h10, 8'h10, 0);
    run(OP_LITERAL_MINUS_ACC, 0, 0, 8'h05, 8'h06, 1);
    run(OP_LITERAL_MINUS_ACC, 0, 0, 8'h20, 8'h01, 0);
    run(OP_FILE_MINUS_ACC, 127, 1, 8'h80, 8'h7f, 0);
    run(OP_FILE_MINUS_ACC, 0, 0, 8'h03, 8'h04, 1);
    run(OP_FILE_MINUS_ACC_BORROW, 5, 1, 8'h10, 8'h0f, 0);
    run(OP_FILE_MINUS_ACC_BORROW, 6, 0, 8'h00, 8'h00, 1);
    run(OP_FILE_MINUS_ACC_BORROW, 7, 0, 8'h00, 8'h00, 0);
    run(OP_NIBBLE_EXCHANGE, 9, 1, 8'h3c, 8'h00, 0);
    run(OP_NIBBLE_EXCHANGE, 10, 0, 8'ha5, 8'h11, 1);
    run(OP_LITERAL_XOR_ACC, 0, 0, 8'h5a, 8'h5a, 0);
    run(OP_LITERAL_XOR_ACC, 0, 0, 8'hff, 8'h0f, 1);
    run(OP_FILE_XOR_ACC, 126, 1, 8'h33, 8'h0c, 0);
    run(OP_FILE_XOR_ACC, 1, 0, 8'h77, 8'h77, 1);
    // Direction loads for every operand, then two illegal operands
    wr(REG_STATUS, 32'h5, RESP_OKAY);
    for (int i = 5; i < 8; i++) begin
      wr(REG_ACC, 32'(i * 17), RESP_OKAY);
      ins(OP_DIRECTION_LOAD, 9'(i), RESP_OKAY);
    end
    ins(OP_DIRECTION_LOAD, 9'h004, RESP_SLVERR);
    ins(OP_DIRECTION_LOAD, 9'h008, RESP_SLVERR);
    rchk("dir", REG_DIR, 32'h00776655);
    chk("port_a", 32'h55, 32'(dir_a));
    chk("port_b", 32'h66, 32'(dir_b));
    chk("port_c", 32'h77, 32'(dir_c));
    rchk("status", REG_STATUS, 32'h1d);
    // Refusals: partial strobe, unknown opcode, unmapped read
    wstrb <= 4'h1;
    ins(OP_LITERAL_XOR_ACC, 9'h0ff, RESP_SLVERR);
    wstrb <= 4'hf;
    ins(4'hf, 9'h0ff, RESP_SLVERR);
    rd(12'h100, d, r);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    // Let the watchdog count up so that clearing it is visible
    do rd(REG_WDOG, d, r); while (d[7:0] < 8'h08);
    ins(OP_SLEEP, 9'h000, RESP_OKAY);
    rd(REG_WDOG, d, r);
    chk("wdog_low", 32'h1, 32'(d[7:0] <= 8'h01));
    // Prescaler restarts from zero, so only a couple of ticks can show
    chk("wdog_pre", 32'h1, 32'(d[15:8] <= 8'h02));
    chk("sleeping", 32'h1, 32'(sleeping));
    chk("osc", 32'h0, 32'(osc_enable));
    rchk("status", REG_STATUS, 32'h35);
    ins(OP_LITERAL_XOR_ACC, 9'h0ff, RESP_SLVERR);
    rchk("acc", REG_ACC, 32'h77);
    wr(REG_WAKE, 32'h1, RESP_OKAY);
    chk("osc", 32'h1, 32'(osc_enable));
    stop_test();
  end
endmodule : subtract_xor_swap_sleep_ops_tb

bind exec_unit exec_unit_checker #(.PRESCALE(PRESCALE)) chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .port_a_direction(port_a_direction),
  .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
  .sleeping(sleeping), .osc_enable(osc_enable)
);
